// File: verilog/fifo_flag_pkg.sv
package fifo_flag_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int DATA_W = 9;
	localparam int OFS_W = 8;
	localparam int DEPTH_DEFAULT = 512;

	// ****************************************
	// Offset register sequence
	// ****************************************
	localparam logic [1:0] OFS_EMPTY_LO = 2'h0;
	localparam logic [1:0] OFS_EMPTY_HI = 2'h1;
	localparam logic [1:0] OFS_FULL_LO = 2'h2;
	localparam logic [1:0] OFS_FULL_HI = 2'h3;
	localparam int OFS_COUNT = 4;

	// Reset values of the four offset registers, entry i at bits [8*i+7:8*i]
	localparam logic [31:0] OFS_RESET = {8'h00, 8'h07, 8'h00, 8'h07};

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic FULL_N_RESET = 1'b1;
	localparam logic ALMOST_FULL_N_RESET = 1'b1;
	localparam logic EMPTY_N_RESET = 1'b0;
	localparam logic ALMOST_EMPTY_N_RESET = 1'b0;
	localparam logic [1:0] OFS_INDEX_RESET = 2'h0;

	// ****************************************
	// Role of the dual-purpose enable input
	// ****************************************
	typedef enum logic [1:0] {
		MODE_TWO_ENABLES = 2'b01,
		MODE_LOAD = 2'b10
	} pin_mode_t;

endpackage

// File: verilog/flag_fifo_store.sv
`timescale 1ns/100ps
module flag_fifo_store #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 512
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Fill side
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [WIDTH-1:0] i_wr_data,
	// Drain side
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [WIDTH-1:0] o_rd_data,
	// Fill level
	output logic [$clog2(DEPTH):0] o_level
);

	// Depth must be a power of two: pointers wrap by overflow
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] level_q;
	logic [WIDTH-1:0] rd_data_q;
	wire push = i_wr_valid && o_wr_ready;
	wire pop = o_rd_valid && i_rd_ready;

	assign o_wr_ready = (level_q != (AW+1)'(DEPTH));
	assign o_rd_valid = (level_q != '0);
	assign o_rd_data = rd_data_q;
	assign o_level = level_q;

	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem[wr_ptr_q] <= i_wr_data;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			level_q <= '0;
			rd_data_q <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
			begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
				rd_data_q <= mem[rd_ptr_q];
			end
			level_q <= level_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// File: verilog/fifo_flag_ctrl.sv
`timescale 1ns/100ps
module fifo_flag_ctrl #(
	parameter int DEPTH = fifo_flag_pkg::DEPTH_DEFAULT
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// Write side
	input wire logic [fifo_flag_pkg::DATA_W-1:0] i_data,
	input wire logic i_write_enable_a_n,
	input wire logic i_write_enable_b_or_load,
	// Read side
	input wire logic i_read_enable_a_n,
	input wire logic i_read_enable_b_n,
	input wire logic i_output_enable_n,
	output logic [fifo_flag_pkg::DATA_W-1:0] o_data,
	output logic o_data_oe,
	// Status flags, all active low
	output logic o_full_flag_n,
	output logic o_almost_full_flag_n,
	output logic o_empty_flag_n,
	output logic o_almost_empty_flag_n,
	// Captured role of the dual-purpose input
	output logic o_load_mode
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

	// ****************************************
	// Threshold decode
	// ****************************************

	function automatic logic [CW-1:0] threshold(input logic [7:0] hi, input logic [7:0] lo);
		logic [15:0] pair;
		pair = {hi, lo};
		threshold = {1'b0, pair[AW-1:0]};
	endfunction

	// ****************************************
	// Mode capture
	// ****************************************

	fifo_flag_pkg::pin_mode_t mode_q;

	// A strap: sampled on every clock while reset is held, so the last level wins
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			mode_q <= i_write_enable_b_or_load ? fifo_flag_pkg::MODE_TWO_ENABLES
				: fifo_flag_pkg::MODE_LOAD;
	end

	assign o_load_mode = (mode_q == fifo_flag_pkg::MODE_LOAD);

	// ****************************************
	// Access decode
	// ****************************************

	logic full_n_q;
	logic empty_n_q;
	logic almost_full_n_q;
	logic almost_empty_n_q;
	logic [1:0] ofs_idx_q;
	logic [7:0] ofs_q [fifo_flag_pkg::OFS_COUNT];
	logic [7:0] ofs_out_q;
	logic show_ofs_q;
	logic fifo_wr_ready;
	logic fifo_rd_valid;
	logic [fifo_flag_pkg::DATA_W-1:0] fifo_rd_data;
	logic [CW-1:0] level_q;

	wire load_low = o_load_mode && !i_write_enable_b_or_load;
	wire read_en = !i_read_enable_a_n && !i_read_enable_b_n;
	wire ofs_wr = load_low && !i_write_enable_a_n;
	// A clash of offset write and read is the outside party's fault; the write wins
	wire ofs_rd = load_low && read_en && !ofs_wr;
	wire ofs_step = ofs_wr || ofs_rd;
	// In either role the write path needs the dual-purpose input high
	wire fifo_wr = !i_write_enable_a_n && i_write_enable_b_or_load
		&& full_n_q && fifo_wr_ready;
	wire fifo_rd = read_en && (!o_load_mode || i_write_enable_b_or_load)
		&& empty_n_q && fifo_rd_valid;
	wire [7:0] ofs_sel = ofs_q[ofs_idx_q];

	// ****************************************
	// Offset registers
	// ****************************************

	genvar gi;
	generate
		for (gi = 0; gi < fifo_flag_pkg::OFS_COUNT; gi++)
		begin : g_ofs
			always_ff @(posedge i_clk_sys)
			begin
				if (i_srst)
					ofs_q[gi] <= fifo_flag_pkg::OFS_RESET[8*gi +: 8];
				else if (ofs_wr && ofs_idx_q == 2'(gi))
					ofs_q[gi] <= i_data[7:0];
			end
		end
	endgenerate

	// Index is only cleared by reset, so leaving load mode keeps the place
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			ofs_idx_q <= fifo_flag_pkg::OFS_INDEX_RESET;
		else if (ofs_step)
			ofs_idx_q <= ofs_idx_q + 2'h1;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			ofs_out_q <= '0;
			show_ofs_q <= 1'b0;
		end
		else if (ofs_rd)
		begin
			ofs_out_q <= ofs_sel;
			show_ofs_q <= 1'b1;
		end
		else if (fifo_rd)
			show_ofs_q <= 1'b0;
	end

	// ****************************************
	// Storage
	// ****************************************

	flag_fifo_store #(
		.WIDTH(fifo_flag_pkg::DATA_W),
		.DEPTH(DEPTH)
	) u_store (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_wr_valid(fifo_wr),
		.o_wr_ready(fifo_wr_ready),
		.i_wr_data(i_data),
		.o_rd_valid(fifo_rd_valid),
		.i_rd_ready(fifo_rd),
		.o_rd_data(fifo_rd_data),
		.o_level(level_q)
	);

	// Both sources are flops; the select only flips with a registered access
	assign o_data = show_ofs_q ? {1'b0, ofs_out_q} : fifo_rd_data;
	assign o_data_oe = !i_output_enable_n;

	// ****************************************
	// Flags
	// ****************************************

	wire [CW-1:0] n_thr = threshold(ofs_q[fifo_flag_pkg::OFS_EMPTY_HI],
		ofs_q[fifo_flag_pkg::OFS_EMPTY_LO]);
	wire [CW-1:0] m_thr = threshold(ofs_q[fifo_flag_pkg::OFS_FULL_HI],
		ofs_q[fifo_flag_pkg::OFS_FULL_LO]);
	wire [CW-1:0] level_d = level_q + CW'(fifo_wr) - CW'(fifo_rd);

	// One clock serves both sides, so the skew lag never arises: every flag
	// settles on the edge of the word read or write that moved it; an offset write moves the almost flags one edge later
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			full_n_q <= fifo_flag_pkg::FULL_N_RESET;
			almost_full_n_q <= fifo_flag_pkg::ALMOST_FULL_N_RESET;
			empty_n_q <= fifo_flag_pkg::EMPTY_N_RESET;
			almost_empty_n_q <= fifo_flag_pkg::ALMOST_EMPTY_N_RESET;
		end
		else
		begin
			full_n_q <= (level_d != DEPTH_C);
			empty_n_q <= (level_d != '0);
			almost_empty_n_q <= (level_d > n_thr);
			almost_full_n_q <= (level_d < DEPTH_C - m_thr);
		end
	end

	assign o_full_flag_n = full_n_q;
	assign o_empty_flag_n = empty_n_q;
	assign o_almost_full_flag_n = almost_full_n_q;
	assign o_almost_empty_flag_n = almost_empty_n_q;

	// ****************************************
	// Checks
	// ****************************************

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	ofs_read_data_a: assert property (ofs_rd
		|=> show_ofs_q && o_data == {1'b0, $past(ofs_sel)})
		else $error("offset read did not reach the outputs");
	fifo_read_data_a: assert property (fifo_rd |=> !show_ofs_q)
		else $error("offset view kept after a word read");
	ofs_write_a: assert property (ofs_wr && ofs_idx_q == fifo_flag_pkg::OFS_EMPTY_LO
		|=> ofs_q[0] == $past(i_data[7:0]) && ofs_idx_q == fifo_flag_pkg::OFS_EMPTY_HI)
		else $error("empty low offset write lost");
	ofs_order_a: assert property (ofs_step |=> ofs_idx_q == $past(ofs_idx_q) + 2'h1)
		else $error("offset sequence did not step");
	ofs_wrap_a: assert property (ofs_step && ofs_idx_q == fifo_flag_pkg::OFS_FULL_HI
		|=> ofs_idx_q == fifo_flag_pkg::OFS_EMPTY_LO)
		else $error("offset sequence did not wrap");
	ofs_hold_a: assert property (!ofs_step |=> $stable(ofs_idx_q))
		else $error("offset sequence moved without access");
	two_enable_ofs_a: assert property (!o_load_mode
		|=> $stable(n_thr) && $stable(m_thr))
		else $error("offsets changed in two enable mode");

	// ****************************************
	// Flag checks
	// ****************************************

	// A fresh offset acts one edge late, so edge checks take the threshold with $past
	almost_empty_a: assert property ($stable(n_thr)
		|-> almost_empty_n_q == (level_q > n_thr))
		else $error("almost empty flag wrong for level");
	aempty_rise_a: assert property ($rose(almost_empty_n_q)
		|-> level_q > $past(n_thr))
		else $error("almost empty flag rose too early");
	aempty_fall_a: assert property ($fell(almost_empty_n_q)
		|-> level_q <= $past(n_thr))
		else $error("almost empty flag fell too early");
	almost_full_a: assert property ($stable(m_thr)
		|-> almost_full_n_q == (level_q < DEPTH_C - m_thr))
		else $error("almost full flag wrong for level");
	afull_fall_a: assert property ($fell(almost_full_n_q)
		|-> level_q >= DEPTH_C - $past(m_thr))
		else $error("almost full flag fell too early");
	afull_rise_a: assert property ($rose(almost_full_n_q)
		|-> DEPTH_C - level_q > $past(m_thr))
		else $error("almost full flag rose too early");
	flag_table_a: assert property (empty_n_q == (level_q != '0)
		&& full_n_q == (level_q != DEPTH_C))
		else $error("empty or full flag wrong for level");
	full_ignore_a: assert property (!full_n_q && !read_en |=> level_q == DEPTH_C)
		else $error("write accepted while full");
	empty_ignore_a: assert property (!empty_n_q && i_write_enable_a_n ##1 1'b1
		|-> level_q == '0)
		else $error("read accepted while empty");
	empty_hold_a: assert property (!empty_n_q && !ofs_rd |=> $stable(o_data))
		else $error("output moved on a read while empty");
	oe_follow_a: assert property (o_data_oe == !i_output_enable_n)
		else $error("output enable does not follow its pin");

	// ****************************************
	// Reset checks
	// ****************************************

	// Most of these watch reset itself, so the default disable is lifted
	mode_hold_a: assert property (1'b1 |=> $stable(mode_q))
		else $error("pin role changed outside reset");
	mode_capture_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		i_srst |=> o_load_mode == !$past(i_write_enable_b_or_load))
		else $error("pin role not taken from reset level");
	reset_state_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		i_srst |=> full_n_q && almost_full_n_q && !empty_n_q && !almost_empty_n_q
		&& o_data == '0 && ofs_idx_q == fifo_flag_pkg::OFS_INDEX_RESET)
		else $error("reset state wrong");
	empty_default_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		i_srst |=> ofs_q[0] == fifo_flag_pkg::OFS_RESET[7:0]
		&& ofs_q[1] == fifo_flag_pkg::OFS_RESET[15:8])
		else $error("empty offset default wrong");
	full_default_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		i_srst |=> ofs_q[2] == fifo_flag_pkg::OFS_RESET[23:16]
		&& ofs_q[3] == fifo_flag_pkg::OFS_RESET[31:24])
		else $error("full offset default wrong");

	ofs_write_c: cover property (ofs_wr ##1 ofs_wr ##1 ofs_wr ##1 ofs_wr);
	ofs_read_c: cover property (ofs_rd ##1 ofs_rd);
	almost_full_c: cover property ($fell(almost_full_n_q));
	almost_empty_c: cover property ($rose(almost_empty_n_q));
	full_c: cover property ($fell(full_n_q));

endmodule

// File: verif/fifo_far_side.sv
`timescale 1ns/100ps
module fifo_far_side (
	// Pins towards the device
	output logic [fifo_flag_pkg::DATA_W-1:0] o_data,
	output logic o_write_enable_a_n,
	output logic o_write_enable_b_or_load,
	output logic o_read_enable_a_n,
	output logic o_read_enable_b_n,
	output logic o_output_enable_n
);

	// ****************************************
	// Pin driver
	// ****************************************
	// Enable vector is {write a, write b or load, read a, read b, output}, all as pin levels
	task automatic drive(input logic [8:0] d, input logic [4:0] en, input logic lmode);
		o_data = d;
		o_write_enable_a_n = en[4];
		o_write_enable_b_or_load = en[3];
		o_read_enable_b_n = en[1];
		o_output_enable_n = en[0];
		// An offset write wins the cycle, so the offset read is withheld
		o_read_enable_a_n = en[2] | (lmode & ~en[3] & ~en[4]);
	endtask

	initial
	begin
		drive(9'h000, 5'h1f, 1'b0);
	end

endmodule

// File: verif/tb_fifo_flag_ctrl.sv
`timescale 1ns/100ps
module tb_fifo_flag_ctrl;
	// Small depth keeps full and almost-full reachable in a short run
	localparam int DEPTH = 16;
	logic i_clk_sys = 1'b0;
	logic i_srst = 1'b1;
	logic [fifo_flag_pkg::DATA_W-1:0] pin_d;
	logic [fifo_flag_pkg::DATA_W-1:0] o_data;
	logic wa_n, wbl, ra_n, rb_n, oe_n;
	logic o_data_oe, full_n, afull_n, empty_n, aempty_n, o_load_mode;
	int bad_count = 0;
	int compares = 0;
	logic [31:0] seed = 32'hebf4;
	logic [31:0] r;
	int q[$];
	int ofs[4];
	int idx;
	int dout;
	bit lmode;

	always #2.5 i_clk_sys = ~i_clk_sys;

	fifo_far_side fifo_far_side_inst (
		.o_data(pin_d),
		.o_write_enable_a_n(wa_n),
		.o_write_enable_b_or_load(wbl),
		.o_read_enable_a_n(ra_n),
		.o_read_enable_b_n(rb_n),
		.o_output_enable_n(oe_n)
	);

	fifo_flag_ctrl #(.DEPTH(DEPTH)) fifo_flag_ctrl_inst (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_data(pin_d),
		.i_write_enable_a_n(wa_n),
		.i_write_enable_b_or_load(wbl),
		.i_read_enable_a_n(ra_n),
		.i_read_enable_b_n(rb_n),
		.i_output_enable_n(oe_n),
		.o_data(o_data),
		.o_data_oe(o_data_oe),
		.o_full_flag_n(full_n),
		.o_almost_full_flag_n(afull_n),
		.o_empty_flag_n(empty_n),
		.o_almost_empty_flag_n(aempty_n),
		.o_load_mode(o_load_mode)
	);

	// ****************************************
	// Reference model
	// ****************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Thresholds are taken before the edge, so a fresh offset acts one edge later
	function automatic logic [14:0] model();
		int n, m, lv;
		bit ow, orr, fw, fr;
		n = (ofs[1] * 256 + ofs[0]) % DEPTH;
		m = (ofs[3] * 256 + ofs[2]) % DEPTH;
		lv = q.size();
		ow = lmode && !wbl && !wa_n;
		orr = lmode && !wbl && !ra_n && !rb_n && !ow;
		fw = !wa_n && wbl && lv != DEPTH;
		fr = !ra_n && !rb_n && (!lmode || wbl) && lv != 0;
		if (i_srst)
		begin
			q.delete();
			ofs = '{7, 0, 7, 0};
			idx = 0;
			dout = 0;
			lmode = !wbl;
		end
		else
		begin
			if (ow)
			begin
				ofs[idx] = pin_d[7:0];
				idx = (idx + 1) % 4;
			end
			if (orr)
			begin
				dout = ofs[idx];
				idx = (idx + 1) % 4;
			end
			if (fr)
				dout = q.pop_front();
			if (fw)
				q.push_back(int'(pin_d));
		end
		lv = q.size();
		return {dout[8:0], !oe_n, lv != DEPTH, lv < DEPTH - m, lv != 0, lv > n, lmode};
	endfunction

	// ****************************************
	// Bench tasks
	// ****************************************
	// Enables are {write a, write b or load, read a, read b}; output enable is random
	task automatic cyc(input logic [8:0] d, input logic [3:0] en);
		logic [31:0] rr;
		logic [14:0] exp;
		logic [14:0] got;
		rr = xs();
		fifo_far_side_inst.drive(d, {en, rr[0]}, lmode);
		@(posedge i_clk_sys);
		#1;
		exp = model();
		got = {o_data, o_data_oe, full_n, afull_n, empty_n, aempty_n, o_load_mode};
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t pins %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reset(input logic strap);
		i_srst = 1'b1;
		repeat (6) cyc(9'h000, {1'b1, strap, 2'b11});
		i_srst = 1'b0;
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic end_of_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		#20000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end

	initial
	begin
		@(posedge i_clk_sys);
		#1;
		reset(1'b0);
		done("reset load mode");
		repeat (5) cyc(9'h000, 4'b1000);
		cyc(9'h010, 4'b0011);
		r = xs();
		cyc({5'h00, r[3:0]}, 4'b0011);
		cyc(9'h000, 4'b1111);
		cyc(9'h000, 4'b0011);
		r = xs();
		cyc({5'h00, r[7:4]}, 4'b0011);
		cyc(9'h0ff, 4'b1011);
		repeat (4) cyc(9'h000, 4'b1000);
		done("offsets");
		repeat (DEPTH + 1)
		begin
			r = xs();
			cyc(r[8:0], 4'b0111);
		end
		repeat (DEPTH + 1) cyc(9'h000, 4'b1100);
		repeat (40)
		begin
			r = xs();
			cyc(r[8:0], {r[9], 1'b1, r[10], r[10]});
		end
		cyc(9'h005, 4'b0000);
		done("fill and drain");
		reset(1'b1);
		cyc(9'h1aa, 4'b0011);
		repeat (40)
		begin
			r = xs();
			cyc(r[8:0], r[12:9]);
		end
		done("two enables");
		end_of_test();
	end

endmodule
